// File: pkg/pos_pkg.sv
// ****************************************************************
// constants and types
// ****************************************************************
package pos_pkg;
  localparam int POS_NUM_FUNC = 2;
  localparam int POS_NUM_SIG_OUT = 9;
  localparam int POS_NUM_GROUP = 5;
  // register offsets
  localparam logic [3:0] POS_REG_CTRL = 4'h0;
  localparam logic [3:0] POS_REG_DELAY = 4'h1;
  localparam logic [3:0] POS_REG_STATUS = 4'h2;
  localparam logic [3:0] POS_REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] POS_REG_IRQ_MASK = 4'h4;
  localparam logic [3:0] POS_REG_ROUTE = 4'h5;
  localparam logic [3:0] POS_REG_ID = 4'h6;
  // ctrl fields
  localparam int POS_CTRL_DUAL = 0;
  localparam int POS_CTRL_RESTART_A = 1;
  localparam int POS_CTRL_RESTART_B = 2;
  localparam int POS_CTRL_FB_CHECK = 3;
  localparam int POS_CTRL_DELAY_EN = 4;
  localparam int POS_CTRL_CLR_ERR = 5;
  // reset values
  localparam logic [31:0] POS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] POS_DELAY_RST = 32'h0000_0000;
  localparam logic [31:0] POS_ROUTE_RST = 32'h0000_0000;
  localparam logic [31:0] POS_ID_VALUE = 32'h0000_0a5c; // arbitrary value
  // timing
  localparam int POS_CLK_MHZ = 100;
  localparam int POS_BLINK_MS = 250;
  localparam int POS_BLINK_CYC = POS_BLINK_MS * 1000 * POS_CLK_MHZ;
  localparam int POS_FB_TIMEOUT_US = 300;
  localparam int POS_FB_TIMEOUT_CYC = POS_FB_TIMEOUT_US * POS_CLK_MHZ;
  // interrupt events
  localparam int POS_EV_OFF_A = 0;
  localparam int POS_EV_OFF_B = 1;
  localparam int POS_EV_ERR_A = 2;
  localparam int POS_EV_ERR_B = 3;
  localparam int POS_EV_SWITCH = 4;
  localparam int POS_NUM_EV = 5;

  typedef enum logic [3:0] {
    POS_ST_OFF = 4'b0001,
    POS_ST_WAIT_ACK = 4'b0010,
    POS_ST_ON = 4'b0100,
    POS_ST_ERROR = 4'b1000
  } pos_state_t;

  typedef struct packed {
    logic field_hit;
    logic warn_hit;
    logic fb_closed;
    logic restart_ack;
  } pos_func_in_t;

  typedef struct packed {
    logic red;
    logic green;
    logic yellow;
    logic blue;
  } pos_leds_t;
endpackage : pos_pkg

// File: rtl/pos_output_logic.sv
`timescale 1ns/10ps
// Operation
// - an object inside the active protective field switches that function's outputs off.
// - outputs come back only with the field free, at once or after acknowledgment per mode.
// - in dual mode each of two functions drives its own output pair from its own field.
// - in single mode a selectable safe delay holds off the second pair's switch-off.
// - six indicators are driven, three for function a and three for function b.
// - bicolour is dark unpowered, red when off, flashing red on error, green when on.
// - yellow is off when interlock unused or released, blinks when occupied, on when ready.
// - blue is lit while an internal call such as an occupied warning field is active.
// - a field pair switchover is monitored and the new pair released only once validated.
// - indication signals are routed to configurable signal outputs by group.
// - optional contactor feedback check; the machine must return the feedback when enabled.
module pos_output_logic
#(
  parameter int BLINK_CYC = pos_pkg::POS_BLINK_CYC,
  parameter int FB_TIMEOUT_CYC = pos_pkg::POS_FB_TIMEOUT_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // field evaluation and machine side
  input wire logic powered,
  input wire pos_pkg::pos_func_in_t func_in [pos_pkg::POS_NUM_FUNC],
  input wire logic switch_req,
  input wire logic switch_valid,
  input wire logic [1:0] out_readback [pos_pkg::POS_NUM_FUNC],
  // outputs
  output logic [1:0] safety_switch_output [pos_pkg::POS_NUM_FUNC],
  output pos_pkg::pos_leds_t leds [pos_pkg::POS_NUM_FUNC],
  output logic switch_release,
  output logic [pos_pkg::POS_NUM_SIG_OUT-1:0] sig_out
);
  import pos_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] delay_cfg, next_delay_cfg;
  logic [31:0] route, next_route;
  logic [POS_NUM_EV-1:0] irq_stat, next_irq_stat;
  logic [POS_NUM_EV-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_rdata;
  logic [POS_NUM_EV-1:0] events;
  logic [POS_NUM_FUNC-1:0] out_on, err_now, occupied, ready;
  logic switch_pending, next_switch_pending;
  logic blink, next_blink;
  logic [31:0] blink_cnt, next_blink_cnt;

  always_comb
  begin
    next_ctrl = ctrl;
    next_delay_cfg = delay_cfg;
    next_route = route;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_rdata = 32'h0000_0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        POS_REG_CTRL: next_ctrl = reg_wdata;
        POS_REG_DELAY: next_delay_cfg = reg_wdata;
        POS_REG_ROUTE: next_route = reg_wdata;
        POS_REG_IRQ_MASK: next_irq_mask = reg_wdata[POS_NUM_EV-1:0];
        POS_REG_IRQ_STAT: next_irq_stat = irq_stat & ~reg_wdata[POS_NUM_EV-1:0];
        default: ;
      endcase
    end
    // a same-cycle event beats the clear
    next_irq_stat = next_irq_stat | events;
    next_ctrl[POS_CTRL_CLR_ERR] = reg_wr && reg_addr == POS_REG_CTRL
                                  && reg_wdata[POS_CTRL_CLR_ERR];
    if (reg_rd)
    begin
      unique case (reg_addr)
        POS_REG_CTRL: next_rdata = ctrl;
        POS_REG_DELAY: next_rdata = delay_cfg;
        POS_REG_STATUS: next_rdata = {22'h00_0000, switch_pending, err_now, occupied,
                                      ready, out_on, 1'b0};
        POS_REG_IRQ_STAT: next_rdata = {27'h000_0000, irq_stat};
        POS_REG_IRQ_MASK: next_rdata = {27'h000_0000, irq_mask};
        POS_REG_ROUTE: next_rdata = route;
        POS_REG_ID: next_rdata = POS_ID_VALUE;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl <= POS_CTRL_RST;
      delay_cfg <= POS_DELAY_RST;
      route <= POS_ROUTE_RST;
      irq_stat <= '0;
      irq_mask <= '0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      delay_cfg <= next_delay_cfg;
      route <= next_route;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_rdata;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ****************************************************************
  // blink timebase and field pair switchover
  // ****************************************************************
  always_comb
  begin
    next_blink_cnt = blink_cnt + 32'd1;
    next_blink = blink;
    if (blink_cnt >= 32'(BLINK_CYC - 1))
    begin
      next_blink_cnt = 32'h0000_0000;
      next_blink = ~blink;
    end
    next_switch_pending = switch_pending;
    // a new request beats validation
    if (switch_req)
      next_switch_pending = 1'b1;
    else if (switch_valid)
      next_switch_pending = 1'b0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
      switch_pending <= 1'b0;
    end
    else
    begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      switch_pending <= next_switch_pending;
    end
  end

  assign switch_release = switch_pending && switch_valid && !switch_req;

  // ****************************************************************
  // per-function output control
  // ****************************************************************
  logic dual;
  assign dual = ctrl[POS_CTRL_DUAL];

  genvar g;
  generate
    for (g = 0; g < POS_NUM_FUNC; g++)
    begin : gen_func
      pos_state_t state, next_state;
      logic [31:0] cnt, next_cnt;
      // cnt watches contactor feedback, hold times the safe delay
      logic [31:0] hold, next_hold;
      logic hit, restart_mode, fb_bad, pair_bad;
      logic [31:0] dly;
      logic drive_on;

      // single mode: pair b follows function a, with optional delay
      assign hit = (dual || g == 0) ? func_in[g].field_hit : func_in[0].field_hit;
      assign restart_mode = ctrl[POS_CTRL_RESTART_A + g];
      assign dly = (!dual && g == 1 && ctrl[POS_CTRL_DELAY_EN]) ? delay_cfg : 32'h0000_0000;
      assign pair_bad = out_readback[g][0] != out_readback[g][1];
      assign fb_bad = ctrl[POS_CTRL_FB_CHECK] && cnt >= 32'(FB_TIMEOUT_CYC)
                      && (func_in[g].fb_closed == (state == POS_ST_ON));

      always_comb
      begin
        next_state = state;
        next_cnt = cnt;
        next_hold = 32'h0000_0000;
        unique case (state)
          POS_ST_ON:
          begin
            if (cnt < 32'(FB_TIMEOUT_CYC))
              next_cnt = cnt + 32'd1;
            if (pair_bad || fb_bad)
              next_state = POS_ST_ERROR;
            else if (hit || switch_pending)
            begin
              next_hold = hold + 32'd1;
              if (hold >= dly)
              begin
                next_state = POS_ST_OFF;
                next_cnt = 32'h0000_0000;
              end
            end
          end
          POS_ST_OFF:
          begin
            if (cnt < 32'(FB_TIMEOUT_CYC))
              next_cnt = cnt + 32'd1;
            if (pair_bad || fb_bad)
              next_state = POS_ST_ERROR;
            // stay off until the field and the switchover are both clear
            else if (!hit && !switch_pending)
            begin
              next_cnt = 32'h0000_0000;
              next_state = restart_mode ? POS_ST_WAIT_ACK : POS_ST_ON;
            end
          end
          POS_ST_WAIT_ACK:
          begin
            if (hit || switch_pending)
              next_state = POS_ST_OFF;
            else if (func_in[g].restart_ack)
              next_state = POS_ST_ON;
          end
          POS_ST_ERROR:
          begin
            next_cnt = 32'h0000_0000;
            // latched until software writes the clear bit
            if (ctrl[POS_CTRL_CLR_ERR])
              next_state = POS_ST_OFF;
          end
        endcase
      end

      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
        begin
          state <= POS_ST_OFF;
          cnt <= 32'h0000_0000;
          hold <= 32'h0000_0000;
          safety_switch_output[g] <= 2'b00;
          leds[g] <= '0;
        end
        else
        begin
          state <= next_state;
          cnt <= next_cnt;
          hold <= next_hold;
          safety_switch_output[g] <= {2{drive_on}};
          leds[g].red <= powered && (next_state == POS_ST_OFF || next_state == POS_ST_WAIT_ACK
                         || (next_state == POS_ST_ERROR && blink));
          leds[g].green <= powered && next_state == POS_ST_ON;
          leds[g].yellow <= powered && restart_mode
                            && ((hit && blink) || next_state == POS_ST_WAIT_ACK);
          leds[g].blue <= powered && func_in[g].warn_hit;
        end
      end

      // both channels are registered from one combinational value
      assign drive_on = next_state == POS_ST_ON && powered;
      assign out_on[g] = state == POS_ST_ON;
      assign err_now[g] = state == POS_ST_ERROR;
      assign occupied[g] = hit;
      assign ready[g] = state == POS_ST_WAIT_ACK;
      assign events[POS_EV_OFF_A + g] = state == POS_ST_ON && next_state != POS_ST_ON;
      assign events[POS_EV_ERR_A + g] = state != POS_ST_ERROR && next_state == POS_ST_ERROR;
    end
  endgenerate

  assign events[POS_EV_SWITCH] = switch_release;

  // ****************************************************************
  // signal output routing
  // ****************************************************************
  logic [POS_NUM_GROUP-1:0] group_sig;
  logic [pos_pkg::POS_NUM_SIG_OUT-1:0] next_sig_out;
  assign group_sig = {|out_on, |err_now, |err_now, func_in[0].warn_hit | func_in[1].warn_hit,
                      &out_on};

  always_comb
  begin
    for (int i = 0; i < POS_NUM_SIG_OUT; i++)
    begin
      next_sig_out[i] = (route[3*i +: 3] < 3'(POS_NUM_GROUP))
                        ? group_sig[route[3*i +: 3]] : 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      sig_out <= '0;
    else
      sig_out <= next_sig_out;
  end
endmodule : pos_output_logic

// File: verification/pos_output_logic_props.sv
`timescale 1ns/10ps
// ********
// port checks
// ********
module pos_output_logic_props
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // watched ports
  input wire logic powered,
  input wire pos_pkg::pos_func_in_t func_in [pos_pkg::POS_NUM_FUNC],
  input wire logic switch_req,
  input wire logic switch_valid,
  input wire logic [1:0] out_readback [pos_pkg::POS_NUM_FUNC],
  input wire logic [1:0] safety_switch_output [pos_pkg::POS_NUM_FUNC],
  input wire pos_pkg::pos_leds_t leds [pos_pkg::POS_NUM_FUNC],
  input wire logic switch_release
);
  import pos_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_switch_held;
    switch_req ##1 switch_req;
  endsequence
  sequence s_readback_bad;
    out_readback[0][0] != out_readback[0][1];
  endsequence
  a_field_off: assert property (func_in[0].field_hit |=> safety_switch_output[0] == 2'b00)
    else $error("pair a on with field occupied");
  a_pair_equal: assert property (
    safety_switch_output[1][0] == safety_switch_output[1][1])
    else $error("pair b channels differ");
  a_unpowered_dark: assert property (!powered |=> leds[0] == '0 && leds[1] == '0)
    else $error("indicators lit while unpowered");
  a_green_on: assert property (powered && $past(powered) |->
    leds[0].green == (safety_switch_output[0] == 2'b11))
    else $error("green does not match pair a");
  a_blue_warn: assert property (powered && $past(powered) && !$past(reset) |->
    leds[0].blue == $past(func_in[0].warn_hit))
    else $error("blue does not follow warning field");
  a_release_valid: assert property (switch_release |-> switch_valid && !switch_req)
    else $error("switchover released without validation");
  a_switch_off: assert property (s_switch_held |=> safety_switch_output[0] == 2'b00)
    else $error("pair a on during switchover");
  a_readback_off: assert property (s_readback_bad |-> ##[1:4]
    safety_switch_output[0] == 2'b00)
    else $error("pair a on after channel mismatch");
  a_error_dark_green: assert property (s_readback_bad |-> ##[1:4] !leds[0].green)
    else $error("green lit after channel mismatch");
endmodule : pos_output_logic_props

bind pos_output_logic pos_output_logic_props u_props (.sys_clk(sys_clk), .reset(reset),
  .powered(powered), .func_in(func_in), .switch_req(switch_req), .switch_valid(switch_valid),
  .out_readback(out_readback), .safety_switch_output(safety_switch_output), .leds(leds),
  .switch_release(switch_release));

// File: verification/pos_machine_model.sv
`timescale 1ns/10ps
// ********
// machine side contactors and readback
// ********
module pos_machine_model
(
  // clock
  input wire logic sys_clk,
  // from device and bench
  input wire logic [1:0] safety_switch_output [pos_pkg::POS_NUM_FUNC],
  input wire logic break_a,
  input wire logic stuck,
  // to device
  output logic [1:0] out_readback [pos_pkg::POS_NUM_FUNC],
  output logic [pos_pkg::POS_NUM_FUNC-1:0] fb_closed
);
  import pos_pkg::*;
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < POS_NUM_FUNC; i++)
    begin
      fb_closed[i] <= ~safety_switch_output[i][0] & ~stuck;
    end
  end
  always_comb
  begin
    out_readback = safety_switch_output;
    out_readback[0][0] = safety_switch_output[0][0] ^ break_a;
  end
endmodule : pos_machine_model

// File: verification/pos_output_logic_bench.sv
`timescale 1ns/10ps
// ********
// bench
// ********
module pos_output_logic_bench;
  import pos_pkg::*;
  localparam int BLINK = 4;
  logic sys_clk, reset, reg_wr, reg_rd, powered, switch_req, switch_valid, irq, rel, break_a;
  logic stuck;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] field, warn, ack, fb;
  pos_func_in_t func_in [POS_NUM_FUNC];
  logic [1:0] rb [POS_NUM_FUNC];
  logic [1:0] sso [POS_NUM_FUNC];
  pos_leds_t leds [POS_NUM_FUNC];
  logic [POS_NUM_SIG_OUT-1:0] sig_out;
  int error_cnt, compares, cycles;
  always_comb
  begin
    for (int i = 0; i < POS_NUM_FUNC; i++)
    begin
      func_in[i] = '{field[i], warn[i], fb[i], ack[i]};
    end
  end
  pos_output_logic #(.BLINK_CYC(BLINK), .FB_TIMEOUT_CYC(8)) dut (.sys_clk(sys_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .powered(powered), .func_in(func_in),
    .switch_req(switch_req), .switch_valid(switch_valid), .out_readback(rb),
    .safety_switch_output(sso), .leds(leds), .switch_release(rel), .sig_out(sig_out));
  pos_machine_model partner (.sys_clk(sys_clk), .safety_switch_output(sso),
    .break_a(break_a), .stuck(stuck), .out_readback(rb), .fb_closed(fb));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(name, reg_rdata, exp);
  endtask : rd_chk
  task automatic toggles(input string name, input logic yel);
    logic [1:0] seen;
    seen = 2'b00;
    repeat (2 * BLINK + 2)
    begin
      tick(1);
      seen[yel ? leds[0].yellow : leds[0].red] = 1'b1;
    end
    check(name, {30'h0, seen}, 32'h0000_0003);
  endtask : toggles
  task automatic t_regs();
    rd_chk("id", POS_REG_ID, POS_ID_VALUE);
    rd_chk("ctrl", POS_REG_CTRL, POS_CTRL_RST);
    rd_chk("route", POS_REG_ROUTE, POS_ROUTE_RST);
    rd_chk("unmapped", 4'hf, 32'h0000_0000);
  endtask : t_regs
  task automatic t_auto();
    tick(3);
    check("pair a", sso[0], 2'b11);
    check("green", leds[0].green, 1'b1);
    check("sig out", sig_out[0], 1'b1);
    field[0] <= 1'b1;
    tick(2);
    check("pair a", sso[0], 2'b00);
    check("red", leds[0].red, 1'b1);
    check("irq masked", irq, 1'b0);
    field[0] <= 1'b0;
    wr(POS_REG_IRQ_MASK, 32'h0000_0001);
    tick(1);
    check("irq", irq, 1'b1);
    wr(POS_REG_IRQ_STAT, 32'h0000_0003);
    tick(1);
    check("irq clear", irq, 1'b0);
    check("pair a", sso[0], 2'b11);
  endtask : t_auto
  task automatic t_restart();
    wr(POS_REG_CTRL, 32'h0000_0002);
    field[0] <= 1'b1;
    toggles("yellow blink", 1'b1);
    field[0] <= 1'b0;
    tick(3);
    check("pair a", sso[0], 2'b00);
    check("yellow", leds[0].yellow, 1'b1);
    ack[0] <= 1'b1;
    tick(3);
    ack[0] <= 1'b0;
    check("pair a", sso[0], 2'b11);
    check("yellow", leds[0].yellow, 1'b0);
  endtask : t_restart
  task automatic t_dual();
    wr(POS_REG_CTRL, 32'h0000_0001);
    field[1] <= 1'b1;
    tick(3);
    check("pair b", sso[1], 2'b00);
    check("pair a", sso[0], 2'b11);
    field[1] <= 1'b0;
    powered <= 1'b0;
    tick(2);
    check("dark", leds[1], 4'h0);
    powered <= 1'b1;
    tick(3);
  endtask : t_dual
  task automatic t_delay();
    wr(POS_REG_DELAY, 32'h0000_0006);
    wr(POS_REG_CTRL, 32'h0000_0010);
    tick(3);
    field[0] <= 1'b1;
    tick(3);
    check("pair a", sso[0], 2'b00);
    check("pair b held", sso[1], 2'b11);
    tick(3);
    check("pair b held", sso[1], 2'b11);
    tick(1);
    check("pair b", sso[1], 2'b00);
    tick(4);
    field[0] <= 1'b0;
    tick(3);
  endtask : t_delay
  task automatic t_switch();
    wr(POS_REG_CTRL, 32'h0000_0000);
    wr(POS_REG_ROUTE, 32'h0000_0011);
    warn[0] <= 1'b1;
    switch_req <= 1'b1;
    tick(3);
    check("pair a", sso[0], 2'b00);
    check("blue", leds[0].blue, 1'b1);
    check("sig warn", sig_out[0], 1'b1);
    switch_req <= 1'b0;
    switch_valid <= 1'b1;
    #1;
    check("release", rel, 1'b1);
    tick(1);
    switch_valid <= 1'b0;
    warn[0] <= 1'b0;
    tick(3);
    check("pair a", sso[0], 2'b11);
    check("sig warn", sig_out[0], 1'b0);
  endtask : t_switch
  task automatic t_error();
    break_a <= 1'b1;
    tick(4);
    check("pair a", sso[0], 2'b00);
    check("sig error", sig_out[1], 1'b1);
    toggles("red flash", 1'b0);
    break_a <= 1'b0;
    wr(POS_REG_CTRL, 32'h0000_0020);
    tick(4);
    check("pair a", sso[0], 2'b11);
  endtask : t_error
  task automatic t_feedback();
    wr(POS_REG_CTRL, 32'h0000_0008);
    tick(12);
    check("pair a", sso[0], 2'b11);
    stuck <= 1'b1;
    field[0] <= 1'b1;
    tick(12);
    rd_chk("status", POS_REG_STATUS, 32'h0000_01e0);
    stuck <= 1'b0;
    field[0] <= 1'b0;
    wr(POS_REG_CTRL, 32'h0000_0028);
    tick(12);
    check("pair a", sso[0], 2'b11);
  endtask : t_feedback
  initial
  begin
    reset = 1'b1;
    {reg_wr, reg_rd, switch_req, switch_valid, break_a, stuck} = '0;
    {field, warn, ack} = '0;
    powered = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    repeat (6) @(posedge sys_clk);
    #1 reset = 1'b0;
    t_regs();
    t_auto();
    t_restart();
    t_dual();
    t_delay();
    t_switch();
    t_error();
    t_feedback();
    wrap_up();
  end
endmodule : pos_output_logic_bench
